// ==== common/wsv_pkg.sv ====
// Shared constants, types and period lookup for the watchdog supervisor
`default_nettype none
package wsv_pkg;
   // Register offsets
   localparam logic [6:0] WSV_ADDR_CTRL = 7'h00;
   localparam logic [6:0] WSV_ADDR_STATE = 7'h05;
   localparam logic [6:0] WSV_ADDR_NVCFG = 7'h74;
   // Control register fields
   localparam int WSV_MODE_HI = 7;
   localparam int WSV_MODE_LO = 5;
   localparam int WSV_PER_HI = 3;
   localparam int WSV_PER_LO = 0;
   // Watchdog mode codes
   localparam logic [2:0] WSV_MODE_AUTO = 3'h1;
   localparam logic [2:0] WSV_MODE_TIMEOUT = 3'h2;
   localparam logic [2:0] WSV_MODE_WINDOW = 3'h4;
   localparam logic [3:0] WSV_PER_DEFAULT = 4'h4;
   // Operating mode codes of the mode controller
   localparam logic [2:0] WSV_OP_SLEEP = 3'h1;
   localparam logic [2:0] WSV_OP_STANDBY = 3'h4;
   localparam logic [2:0] WSV_OP_NORMAL = 3'h7;
   // Phase codes
   localparam logic [1:0] WSV_PH_OFF = 2'h0;
   localparam logic [1:0] WSV_PH_FIRST = 2'h1;
   localparam logic [1:0] WSV_PH_SECOND = 2'h2;
   // Reset cause codes
   localparam logic [4:0] WSV_RC_EARLY = 5'h0E;
   localparam logic [4:0] WSV_RC_OVERFLOW = 5'h0F;
   localparam logic [4:0] WSV_RC_ILLEGAL = 5'h10;
   // Non-volatile config fields and factory value
   localparam int WSV_NV_UV_HI = 5;
   localparam int WSV_NV_UV_LO = 4;
   localparam int WSV_NV_FNM = 3;
   localparam int WSV_NV_SDM = 2;
   localparam int WSV_NV_SLP = 0;
   localparam logic [7:0] WSV_NV_MASK = 8'h3D;
   localparam logic [7:0] WSV_NV_FACTORY = 8'h08;
   // Timing
   localparam int WSV_CLK_HZ = 25000000;
   localparam int WSV_MS_PER_S = 1000;
   localparam int WSV_TICK_CYCLES = WSV_CLK_HZ / WSV_MS_PER_S;

   // Behaviour of the watchdog counter
   typedef enum logic [1:0] {
      WSV_BEH_OFF = 2'b00,
      WSV_BEH_TIMEOUT = 2'b01,
      WSV_BEH_WINDOW = 2'b10
   } wsv_beh_t;

   // One register access from the serial interface
   typedef struct packed {
      logic wr;
      logic rd;
      logic [6:0] addr;
      logic [7:0] wdata;
   } wsv_reg_req_t;

   // Period code to milliseconds; zero marks an invalid code
   function automatic logic [12:0] wsv_period_ms(input logic [3:0] code);
      case (code)
         4'h8: wsv_period_ms = 13'h0008;
         4'h1: wsv_period_ms = 13'h0010;
         4'h2: wsv_period_ms = 13'h0020;
         4'hB: wsv_period_ms = 13'h0040;
         4'h4: wsv_period_ms = 13'h0080;
         4'hD: wsv_period_ms = 13'h0100;
         4'hE: wsv_period_ms = 13'h0400;
         4'h7: wsv_period_ms = 13'h1000;
         default: wsv_period_ms = 13'h0000;
      endcase
   endfunction
endpackage
`default_nettype wire

// ==== logic/wsv_supervisor.sv ====
// Watchdog supervisor with mode control, period timer and config bits
`default_nettype none

// Notes on behaviour
// - Each valid write to the watchdog control register, except a change in Normal, restarts the timer.
// - A valid write changing mode or period takes effect immediately outside Normal; in Normal it is discarded.
// - Mode resets to Timeout, or Autonomous if software-development enabled.
// - Period field accepts only eight redundant codes; 128 ms default.
// - Invalid mode or period code discards the write, raises serial fault.
// - Changing mode or period in Normal forces reset, cause 10000.
// - Forced-normal control disables the watchdog in every operating mode.
// - Window selected: Window in Normal, Timeout in Standby/Sleep, else off.
// - Timeout selected: Timeout in Normal, Standby, Sleep, else off.
// - Autonomous: Timeout in Normal or Standby with receive low, unless software-development set; else off.
// - Window: trigger in first half causes a system reset.
// - Window: second-half trigger restarts; overflow resets.
// - Reset cause 01110 for early trigger, 01111 for overflow.
// - Timeout: trigger restarts anytime; first overflow sets failure flag.
// - Timeout: overflow with failure flag already set causes reset.
// - Phase reads 00 off, 01 first half, 10 second half.
// - Status bits 3 and 2 show forced-normal and software-development.
// - Forced-normal and software-development bits live in non-volatile config.
// - Sleep-inhibit bit 0 set makes Sleep commands ignored.
// - Config bits 5:4 load the undervoltage threshold at start-up.
module wsv_supervisor #(
   parameter int TICK_CYCLES = wsv_pkg::WSV_TICK_CYCLES // Clocks per millisecond
) (
   input wire logic core_clk, // 25 MHz clock
   input wire logic reset_n, // Synchronous system reset
   input wire logic power_up, // High on the reset that follows power-on
   input wire wsv_pkg::wsv_reg_req_t reg_req, // Register access
   output logic [7:0] reg_rdata, // Read data, valid cycle after rd
   input wire logic [2:0] op_mode, // Current operating mode
   input wire logic rxd_pin, // Receive pin level, asynchronous
   input wire logic serial_fault_en, // Serial fault event enable
   input wire logic wd_fail_clr, // Clear pulse for the failure flag
   output logic wd_reset_req, // One-cycle system reset request
   output logic [4:0] reset_cause, // Cause of last watchdog reset
   output logic serial_fault_event, // One-cycle serial fault event
   output logic wd_failure_flag, // Watchdog failure pending
   output logic sleep_inhibit, // Sleep commands to be ignored
   output logic [1:0] uv_threshold_sel // Undervoltage threshold selection
);

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   logic [2:0] mode_q;
   logic [3:0] period_q;
   logic [7:0] nv_q;
   logic [14:0] tick_q;
   logic [12:0] ms_q;
   logic rxd_s1_q, rxd_s2_q;
   logic [7:0] rdata_q;
   logic rst_req_q, sf_q, wdf_q;
   logic [4:0] cause_q;
   logic [1:0] uv_q;

   // ----------------------------------------------------------------
   // Decode of control writes
   // ----------------------------------------------------------------
   wire logic [2:0] new_mode = reg_req.wdata[wsv_pkg::WSV_MODE_HI:wsv_pkg::WSV_MODE_LO];
   wire logic [3:0] new_per = reg_req.wdata[wsv_pkg::WSV_PER_HI:wsv_pkg::WSV_PER_LO];
   wire logic ctrl_wr = reg_req.wr && (reg_req.addr == wsv_pkg::WSV_ADDR_CTRL);
   wire logic nv_wr = reg_req.wr && (reg_req.addr == wsv_pkg::WSV_ADDR_NVCFG);
   wire logic mode_ok = (new_mode == wsv_pkg::WSV_MODE_AUTO) ||
                        (new_mode == wsv_pkg::WSV_MODE_TIMEOUT) ||
                        (new_mode == wsv_pkg::WSV_MODE_WINDOW);
   wire logic per_ok = wsv_pkg::wsv_period_ms(new_per) != 13'h0000;
   wire logic bad_wr = ctrl_wr && !(mode_ok && per_ok);
   wire logic changed = (new_mode != mode_q) || (new_per != period_q);
   wire logic in_normal = (op_mode == wsv_pkg::WSV_OP_NORMAL);
   wire logic illegal_wr = ctrl_wr && mode_ok && per_ok && in_normal && changed;
   wire logic trig = ctrl_wr && mode_ok && per_ok && !illegal_wr;

   // ----------------------------------------------------------------
   // Effective behaviour from mode, operating mode and config
   // ----------------------------------------------------------------
   wire logic forced_normal_state = nv_q[wsv_pkg::WSV_NV_FNM];
   wire logic sw_dev_state = nv_q[wsv_pkg::WSV_NV_SDM];
   wire logic in_stby = (op_mode == wsv_pkg::WSV_OP_STANDBY);
   wire logic in_sleep = (op_mode == wsv_pkg::WSV_OP_SLEEP);
   wsv_pkg::wsv_beh_t beh;
   always_comb
   begin
      beh = wsv_pkg::WSV_BEH_OFF;
      if (forced_normal_state)
         beh = wsv_pkg::WSV_BEH_OFF;
      else if (mode_q == wsv_pkg::WSV_MODE_WINDOW)
         beh = in_normal ? wsv_pkg::WSV_BEH_WINDOW :
               (in_stby || in_sleep) ? wsv_pkg::WSV_BEH_TIMEOUT : wsv_pkg::WSV_BEH_OFF;
      else if (mode_q == wsv_pkg::WSV_MODE_TIMEOUT)
         beh = (in_normal || in_stby || in_sleep) ?
               wsv_pkg::WSV_BEH_TIMEOUT : wsv_pkg::WSV_BEH_OFF;
      else if (!sw_dev_state && (in_normal || (in_stby && !rxd_s2_q)))
         beh = wsv_pkg::WSV_BEH_TIMEOUT;
   end

   // ----------------------------------------------------------------
   // Timer position and events
   // ----------------------------------------------------------------
   wire logic [12:0] per_ms = wsv_pkg::wsv_period_ms(period_q);
   wire logic first_half = ms_q < (per_ms >> 1);
   wire logic ms_tick = (tick_q == 15'(TICK_CYCLES - 1));
   wire logic running = (beh != wsv_pkg::WSV_BEH_OFF);
   wire logic ovf = running && ms_tick && (ms_q == per_ms - 13'h0001);
   wire logic is_win = (beh == wsv_pkg::WSV_BEH_WINDOW);
   wire logic is_to = (beh == wsv_pkg::WSV_BEH_TIMEOUT);
   wire logic early = trig && is_win && first_half;
   wire logic win_ovf = ovf && is_win && !trig;
   wire logic to_ovf = ovf && is_to && !trig;
   wire logic to_fail = to_ovf && wdf_q;
   wire logic restart = trig || !running || (to_ovf && !wdf_q);
   wire logic [1:0] phase = !running ? wsv_pkg::WSV_PH_OFF :
                            first_half ? wsv_pkg::WSV_PH_FIRST : wsv_pkg::WSV_PH_SECOND;
   wire logic [7:0] state_rd = {4'h0, forced_normal_state, sw_dev_state, phase};
   wire logic [7:0] ctrl_rd = {mode_q, 1'b0, period_q};
   wire logic [7:0] rd_mux = (reg_req.addr == wsv_pkg::WSV_ADDR_CTRL) ? ctrl_rd :
                             (reg_req.addr == wsv_pkg::WSV_ADDR_STATE) ? state_rd :
                             (reg_req.addr == wsv_pkg::WSV_ADDR_NVCFG) ? nv_q : 8'h00;

   // Receive pin synchroniser
   always_ff @(posedge core_clk)
   begin
      rxd_s1_q <= rxd_pin;
      rxd_s2_q <= rxd_s1_q;
   end

   // Non-volatile config: factory value only on power-up
   always_ff @(posedge core_clk)
   begin
      if (!reset_n && power_up)
         nv_q <= wsv_pkg::WSV_NV_FACTORY;
      else if (reset_n && nv_wr)
         nv_q <= reg_req.wdata & wsv_pkg::WSV_NV_MASK;
   end

   // Start-up threshold capture and sleep inhibit
   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
         uv_q <= nv_q[wsv_pkg::WSV_NV_UV_HI:wsv_pkg::WSV_NV_UV_LO];
   end
   assign uv_threshold_sel = uv_q;
   assign sleep_inhibit = nv_q[wsv_pkg::WSV_NV_SLP];

   // Mode and period; new values apply at once
   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         mode_q <= sw_dev_state ? wsv_pkg::WSV_MODE_AUTO : wsv_pkg::WSV_MODE_TIMEOUT;
         period_q <= wsv_pkg::WSV_PER_DEFAULT;
      end
      else if (trig)
      begin
         mode_q <= new_mode;
         period_q <= new_per;
      end
   end

   // Millisecond divider and period counter
   always_ff @(posedge core_clk)
   begin
      if (!reset_n || restart || win_ovf || to_fail)
      begin
         tick_q <= 15'h0000;
         ms_q <= 13'h0000;
      end
      else if (ms_tick)
      begin
         tick_q <= 15'h0000;
         ms_q <= ms_q + 13'h0001;
      end
      else
         tick_q <= tick_q + 15'h0001;
   end

   // Failure flag; a set wins over a clear
   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
         wdf_q <= 1'b0;
      else if (to_ovf && !wdf_q)
         wdf_q <= 1'b1;
      else if (wd_fail_clr)
         wdf_q <= 1'b0;
   end

   // Reset request, cause and serial fault event
   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         rst_req_q <= 1'b0;
         sf_q <= 1'b0;
         cause_q <= 5'h00;
      end
      else
      begin
         rst_req_q <= illegal_wr || early || win_ovf || to_fail;
         sf_q <= (bad_wr || illegal_wr) && serial_fault_en;
         if (illegal_wr)
            cause_q <= wsv_pkg::WSV_RC_ILLEGAL;
         else if (early)
            cause_q <= wsv_pkg::WSV_RC_EARLY;
         else if (win_ovf || to_fail)
            cause_q <= wsv_pkg::WSV_RC_OVERFLOW;
      end
   end

   // Registered read data
   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
         rdata_q <= 8'h00;
      else if (reg_req.rd)
         rdata_q <= rd_mux;
   end

   assign reg_rdata = rdata_q;
   assign wd_reset_req = rst_req_q;
   assign reset_cause = cause_q;
   assign serial_fault_event = sf_q;
   assign wd_failure_flag = wdf_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   sequence s_early_trig;
      trig && is_win && first_half;
   endsequence

   trig_restart_a: assert property (trig |=> ms_q == 13'h0000)
      else $error("trigger did not restart timer");
   apply_now_a: assert property (trig |=> mode_q == $past(new_mode))
      else $error("new mode not applied");
   bad_discard_a: assert property (bad_wr |=> $stable(mode_q) && $stable(period_q))
      else $error("invalid write not discarded");
   normal_change_a: assert property (illegal_wr |=> rst_req_q && cause_q == 5'h10)
      else $error("normal mode change not reset");
   forced_off_a: assert property (forced_normal_state |-> phase == 2'h0)
      else $error("watchdog active in forced normal");
   early_reset_a: assert property (s_early_trig |=> rst_req_q && cause_q == 5'h0E)
      else $error("early trigger not reset");
   first_fail_a: assert property (to_ovf && !wdf_q |=> wdf_q && !rst_req_q)
      else $error("first overflow not flagged");
   second_fail_a: assert property (to_fail |=> rst_req_q ##1 !rst_req_q)
      else $error("overflow with failure not reset");

   // Window behaviour: a late trigger restarts, an overflow resets
   sequence s_late_trig;
      trig && is_win && !first_half;
   endsequence

   sequence s_win_ovf;
      ovf && is_win && !ctrl_wr;
   endsequence

   late_trig_a: assert property (s_late_trig |=> !rst_req_q && ms_q == 13'h0000)
      else $error("late trigger not accepted");
   win_ovf_a: assert property (s_win_ovf |=>
      rst_req_q && cause_q == wsv_pkg::WSV_RC_OVERFLOW)
      else $error("window overflow not reset");

   // Timeout behaviour: triggers at any time, overflow cause
   to_trig_a: assert property (trig && is_to |=> !rst_req_q && ms_q == 13'h0000)
      else $error("timeout trigger not accepted");
   to_cause_a: assert property (to_fail && !ctrl_wr |=>
      cause_q == wsv_pkg::WSV_RC_OVERFLOW)
      else $error("timeout overflow cause wrong");
   set_wins_a: assert property (to_ovf && !wdf_q && wd_fail_clr |=> wdf_q)
      else $error("failure clear beat the set");

   // Serial fault event only for refused writes, and only when enabled
   sequence s_bad_write;
      bad_wr && serial_fault_en;
   endsequence

   bad_event_a: assert property (s_bad_write |=> sf_q)
      else $error("serial fault event missing");
   no_event_a: assert property (!bad_wr && !illegal_wr |=> !sf_q)
      else $error("spurious serial fault event");
   keep_cfg_a: assert property (illegal_wr |=> $stable(mode_q) && $stable(period_q))
      else $error("illegal change applied");

   // Effective behaviour against selection, operating mode and config
   sequence s_to_select;
      mode_q == wsv_pkg::WSV_MODE_TIMEOUT && !forced_normal_state && (in_normal || in_stby || in_sleep);
   endsequence

   window_only_a: assert property (is_win |-> in_normal && !forced_normal_state)
      else $error("window behaviour outside normal");
   to_select_a: assert property (s_to_select |-> is_to)
      else $error("timeout selection not running");
   auto_dev_a: assert property (mode_q == wsv_pkg::WSV_MODE_AUTO && sw_dev_state |->
      !running)
      else $error("autonomous watchdog active in development");
   period_ok_a: assert property (per_ms != 13'h0000)
      else $error("illegal period held");
   ms_bound_a: assert property (ms_q < per_ms)
      else $error("period counter beyond period");
endmodule
`default_nettype wire

// ==== sim/wsv_mcu_model.sv ====
// Microcontroller model that reaches the watchdog registers
`default_nettype none
module wsv_mcu_model (
   input wire logic core_clk, // Bus clock
   output var wsv_pkg::wsv_reg_req_t reg_req, // Register access
   input wire logic [7:0] reg_rdata // Read data
);
   timeunit 1ns;
   timeprecision 1ns;
   // -------------------------------------------
   // Access tasks
   // -------------------------------------------
   // Idle with strobes low
   initial reg_req = '0;
   // Write: strobe for one edge, then inverted leftovers on the lines
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_req <= '{1'b1, 1'b0, a, d};
      @(posedge core_clk);
      reg_req <= '{1'b0, 1'b0, ~a, ~d};
   endtask
   // Read: strobe, data taken once the answering edge has landed
   task automatic rd(input logic [6:0] a, output logic [7:0] q);
      @(posedge core_clk);
      reg_req <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge core_clk);
      reg_req <= '{1'b0, 1'b0, ~a, 8'hA5};
      #1;
      q = reg_rdata;
   endtask
endmodule
`default_nettype wire

// ==== sim/wsv_supervisor_tb_top.sv ====
// Self-checking bench for the watchdog supervisor
`default_nettype none
module wsv_supervisor_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [6:0] CT = wsv_pkg::WSV_ADDR_CTRL;
   localparam logic [6:0] ST = wsv_pkg::WSV_ADDR_STATE;
   localparam logic [6:0] NV = wsv_pkg::WSV_ADDR_NVCFG;
   localparam logic [2:0] OPS [4] = '{3'h1, 3'h4, 3'h7, 3'h0};
   localparam logic [2:0] MDS [3] = '{3'h1, 3'h2, 3'h4};
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic power_up = 1'b1;
   logic [2:0] op_mode = 3'h4;
   logic rxd_pin = 1'b1;
   logic serial_fault_en = 1'b1;
   logic wd_fail_clr = 1'b0;
   wsv_pkg::wsv_reg_req_t reg_req;
   logic [7:0] reg_rdata, q, d, cur;
   logic [4:0] reset_cause;
   logic wd_reset_req, serial_fault_event, wd_failure_flag, sleep_inhibit;
   logic [1:0] uv_threshold_sel;
   int fails = 0, num_checks = 0, cyc = 0, nrst = 0, n, seed = 62;
   // -------------------------------------------
   // Design, partner and helpers
   // -------------------------------------------
   wsv_supervisor #(.TICK_CYCLES(4)) u_wsv_supervisor (.core_clk(core_clk),
      .reset_n(reset_n), .power_up(power_up), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .op_mode(op_mode), .rxd_pin(rxd_pin), .serial_fault_en(serial_fault_en),
      .wd_fail_clr(wd_fail_clr), .wd_reset_req(wd_reset_req), .reset_cause(reset_cause),
      .serial_fault_event(serial_fault_event), .wd_failure_flag(wd_failure_flag),
      .sleep_inhibit(sleep_inhibit), .uv_threshold_sel(uv_threshold_sel));
   wsv_mcu_model u_wsv_mcu_model (.core_clk(core_clk), .reg_req(reg_req),
      .reg_rdata(reg_rdata));
   // 25 MHz clock
   initial forever #20 core_clk = ~core_clk;
   // Cycle ceiling and count of reset requests
   always @(posedge core_clk)
   begin
      cyc <= cyc + 1;
      if (wd_reset_req === 1'b1) nrst <= nrst + 1;
      if (cyc == 40000)
      begin
         fails++;
         results();
      end
   end
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic step(input int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask
   // Bounded wait for a reset request, cycles waited in n
   task automatic wait_rst();
      n = 0;
      while (wd_reset_req !== 1'b1 && n < 60)
      begin
         step(1);
         n++;
      end
   endtask
   task automatic clr_fail();
      @(posedge core_clk) wd_fail_clr <= 1'b1;
      @(posedge core_clk) wd_fail_clr <= 1'b0;
      step(1);
   endtask
   function automatic logic ok(input logic [7:0] c);
      return c[7:5] inside {3'h1, 3'h2, 3'h4} && c[3:0] inside {4'h8, 4'h1, 4'h2, 4'hB,
         4'h4, 4'hD, 4'hE, 4'h7};
   endfunction
   function automatic logic wd_on(input logic [2:0] m, input logic [2:0] op, input logic x,
      input logic [7:0] nv);
      if (nv[3]) return 1'b0;
      if (m == 3'h1) return !nv[2] && (op == 3'h7 || (op == 3'h4 && !x));
      return (m != 3'h1) && op inside {3'h1, 3'h4, 3'h7};
   endfunction
   // Main sequence
   initial
   begin
      repeat (8) @(posedge core_clk);
      reset_n <= 1'b1;
      power_up <= 1'b0;
      u_wsv_mcu_model.rd(CT, q);
      chk("ctrl", q, 8'h44);
      u_wsv_mcu_model.rd(ST, q);
      chk("state", q, 8'h08);
      u_wsv_mcu_model.rd(NV, q);
      chk("nvcfg", q, 8'h08);
      chk("uv", uv_threshold_sel, 8'h00);
      u_wsv_mcu_model.wr(NV, 8'h01);
      step(1);
      chk("slp", sleep_inhibit, 8'h01);
      u_wsv_mcu_model.wr(NV, 8'hFF);
      u_wsv_mcu_model.rd(NV, q);
      chk("nvmask", q, 8'h3D);
      // Every mode against every operating mode and receive level
      for (int v = 0; v < 3; v++)
      begin
         d = 8'(v * 4);
         u_wsv_mcu_model.wr(NV, d);
         for (int m = 0; m < 3; m++)
            for (int o = 0; o < 8; o++)
            begin
               @(posedge core_clk) op_mode <= 3'h4;
               u_wsv_mcu_model.wr(CT, {MDS[m], 5'h04});
               @(posedge core_clk) op_mode <= OPS[o / 2];
               rxd_pin <= o[0];
               step(6);
               u_wsv_mcu_model.rd(ST, q);
               cur = 8'(wd_on(MDS[m], OPS[o / 2], o[0], d));
               chk("on", q[1:0] != 2'h0, cur);
               chk("flags", q[3:2], d[3:2]);
            end
      end
      // Random and corrupt control writes in Standby
      @(posedge core_clk) op_mode <= 3'h4;
      cur = 8'h84;
      for (int i = 0; i < 20; i++)
      begin
         n = $random(seed);
         d = (i == 0) ? 8'h64 : (i == 1) ? 8'h49 : 8'(n);
         if (n[8] && i > 1) d[7:5] = MDS[n[10:9] % 3];
         d[4] = 1'b0;
         @(posedge core_clk) serial_fault_en <= n[11] | (i < 2);
         u_wsv_mcu_model.wr(CT, d);
         #1;
         chk("sfe", serial_fault_event, !ok(d) && serial_fault_en);
         if (ok(d)) cur = d;
         u_wsv_mcu_model.rd(CT, q);
         chk("ctrl", q, cur);
      end
      // Timeout: first overflow flags, second resets; forced-normal off first
      @(posedge core_clk) serial_fault_en <= 1'b1;
      u_wsv_mcu_model.wr(NV, 8'h00);
      clr_fail();
      d = 8'(nrst);
      u_wsv_mcu_model.wr(CT, 8'h48);
      n = 0;
      while (wd_failure_flag !== 1'b1 && n < 60)
      begin
         step(1);
         n++;
      end
      chk("ovf1", n >= 30 && n <= 35, 1'b1);
      chk("norst", 8'(nrst), d);
      wait_rst();
      chk("ovf2", n >= 28 && n <= 35, 1'b1);
      chk("cause", reset_cause, 8'h0F);
      clr_fail();
      chk("clr", wd_failure_flag, 8'h00);
      // Window in Normal: early, in time, overflow, illegal change
      u_wsv_mcu_model.wr(CT, 8'h88);
      @(posedge core_clk) op_mode <= 3'h7;
      u_wsv_mcu_model.wr(CT, 8'h88);
      #1;
      chk("early", wd_reset_req, 8'h01);
      chk("cause", reset_cause, 8'h0E);
      step(20);
      d = 8'(nrst);
      u_wsv_mcu_model.wr(CT, 8'h88);
      step(1);
      chk("late", 8'(nrst), d);
      wait_rst();
      chk("wovf", n >= 30 && n <= 35, 1'b1);
      chk("cause", reset_cause, 8'h0F);
      u_wsv_mcu_model.wr(CT, 8'h84);
      #1;
      chk("illegal", {wd_reset_req, serial_fault_event}, 8'h03);
      chk("cause", reset_cause, 8'h10);
      u_wsv_mcu_model.rd(CT, q);
      chk("ctrl", q, 8'h88);
      // Warm reset keeps config, loads threshold, starts Autonomous
      @(posedge core_clk) op_mode <= 3'h4;
      u_wsv_mcu_model.wr(NV, 8'h24);
      @(posedge core_clk) reset_n <= 1'b0;
      step(8);
      @(posedge core_clk) reset_n <= 1'b1;
      u_wsv_mcu_model.rd(CT, q);
      chk("ctrl", q, 8'h24);
      u_wsv_mcu_model.rd(ST, q);
      chk("state", q, 8'h04);
      chk("uv", uv_threshold_sel, 8'h02);
      chk("cause", reset_cause, 8'h00);
      results();
   end
endmodule
`default_nettype wire
